// ### touch_adc_pkg.sv
// Shared constants for the touch converter conversion-control block.
package touch_adc_pkg;

	// Clock and timing figures in their own units.
	localparam int unsigned MCLK_NS = 4;
	localparam int unsigned CONV_CLK_NS = 500;
	localparam int unsigned TEMP_SETTLE_NS = 16000;
	localparam int unsigned INTERVAL_BASE_US = 550;
	localparam int unsigned INTERVAL_STEP_US = 35;
	localparam int unsigned INTERVAL_MAX_US = 9440;

	// Derived counts: mclk cycles per conversion clock, and conversion clock ticks.
	localparam int unsigned CONV_CLK_CYCLES = CONV_CLK_NS / MCLK_NS;
	localparam int unsigned TEMP_SETTLE_TICKS = (TEMP_SETTLE_NS + CONV_CLK_NS - 1) / CONV_CLK_NS;
	localparam int unsigned INTERVAL_BASE_TICKS = (INTERVAL_BASE_US * 1000) / CONV_CLK_NS;
	localparam int unsigned INTERVAL_STEP_TICKS = (INTERVAL_STEP_US * 1000) / CONV_CLK_NS;
	localparam int unsigned INTERVAL_MAX_TICKS = (INTERVAL_MAX_US * 1000) / CONV_CLK_NS;
	localparam int unsigned ACQ_BASE_TICKS = 4;
	localparam int unsigned TICK_W = 15;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] CTRL1_IDX = 6'h01;
	localparam logic [5:0] CTRL2_IDX = 6'h02;
	localparam logic [5:0] CTRL3_IDX = 6'h03;
	localparam logic [5:0] STATUS_IDX = 6'h0F;

	// Reset values.
	localparam logic [15:0] CTRL1_RESET = 16'h0000;
	localparam logic [15:0] CTRL2_RESET = 16'h4040;
	localparam logic [15:0] CTRL3_RESET = 16'h0000;

	// Field positions of the first control register.
	localparam int unsigned CHAN_LSB = 12;
	localparam int unsigned MODE_LSB = 10;
	localparam int unsigned ACQ_LSB = 8;
	localparam int unsigned TMR_LSB = 0;
	// Pin-function bit of the second control register.
	localparam int unsigned GPIO_EN_BIT = 13;
	// Sequence channel mask of the third control register: bit n selects channel code n.
	localparam int unsigned SEQ_MASK_LSB = 0;

	// Status register field positions.
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_TOUCH_BIT = 1;
	localparam int unsigned ST_WAIT_BIT = 2;
	localparam int unsigned ST_CHAN_LSB = 4;

	// Conversion modes.
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_SLAVE = 2'h2;
	localparam logic [1:0] MODE_MASTER = 2'h3;

	// Channel codes with special handling.
	localparam logic [2:0] CH_NONE = 3'h0;
	localparam logic [2:0] CH_TEMP = 3'h1;
	localparam logic [2:0] CH_VBAT = 3'h2;
	localparam logic [2:0] CH_AUX = 3'h3;

endpackage : touch_adc_pkg

// ### conv_timer_if.sv
// Interface between the sequencer and its conversion clock timer.
`timescale 1ns/1ns
interface conv_timer_if;
	logic start;
	logic halt;
	logic [touch_adc_pkg::TICK_W-1:0] ticks;
	logic expired;

	modport ctrl (output start, output halt, output ticks, input expired);
	modport timer (input start, input halt, input ticks, output expired);
endinterface : conv_timer_if

// ### conv_timer.sv
// Conversion clock divider and tick down-counter for settle and interval periods.
`timescale 1ns/1ns
module conv_timer #(
	parameter int unsigned CONV_CLK_CYCLES = touch_adc_pkg::CONV_CLK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	conv_timer_if.timer tif
);
	localparam int unsigned DIV_W = $clog2(CONV_CLK_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(CONV_CLK_CYCLES - 1);

	logic [DIV_W-1:0] div_q;
	logic [touch_adc_pkg::TICK_W-1:0] cnt_q;
	logic run_q;
	logic expired_q;

	if (CONV_CLK_CYCLES < 1)
	begin : g_bad_div
		$error("conv_timer needs at least one mclk cycle per tick.");
	end

	// A start realigns the divider, so a period of N ticks is exactly N divider rounds.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div_q <= '0;
			cnt_q <= '0;
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end
		else
		begin
			expired_q <= 1'b0;
			if (tif.start)
			begin
				div_q <= DIV_RELOAD;
				cnt_q <= tif.ticks;
				run_q <= 1'b1;
			end
			else if (tif.halt)
			begin
				run_q <= 1'b0;
			end
			else if (run_q)
			begin
				if (div_q == '0)
				begin
					div_q <= DIV_RELOAD;
					if (cnt_q <= 1)
					begin
						run_q <= 1'b0;
						expired_q <= 1'b1;
					end
					else
					begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				else
				begin
					div_q <= div_q - 1'b1;
				end
			end
		end
	end

	assign tif.expired = expired_q;
endmodule : conv_timer

// ### touch_adc_conversion_control.sv
// Conversion control of a touch screen converter: APB registers, sequencer and timing.
`timescale 1ns/1ns
//
// Behaviour
// - Channel 001 is temperature; 000 selects nothing.
// - Mode field 11:10 selects none/single/slave/master.
// - Acquisition field 9:8 gives 4/8/16/32 ticks.
// - Temperature channel settles a fixed 16 us.
// - Interval is 550 us plus 35 us steps.
// - Slave mode starts interval right after sequence.
// - Master mode restarts interval only while touched.
// - Master release halts timer; touch starts immediately.
// - Pin in GPIO function ignores aux and battery.
// - Aux and battery both selected: battery only.
// - Single/slave end with timer zero clears mode.
// - Manual channel field 14:12 drives single conversion.
// - Sequence channels come from third control register.
module touch_adc_conversion_control #(
	parameter int unsigned CONV_CLK_CYCLES = touch_adc_pkg::CONV_CLK_CYCLES,
	parameter int unsigned INTERVAL_BASE_TICKS = touch_adc_pkg::INTERVAL_BASE_TICKS,
	parameter int unsigned INTERVAL_STEP_TICKS = touch_adc_pkg::INTERVAL_STEP_TICKS
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic touch_i,
	input wire logic conv_done_i,
	output logic conv_start_o,
	output logic [2:0] conv_channel_o,
	output logic acquire_o,
	output logic busy_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TOUCH, ST_NEXT, ST_SETTLE, ST_CONVERT,
		ST_INTERVAL} seq_state_e;

	conv_timer_if tif ();

	logic [15:0] ctrl1_q;
	logic [15:0] ctrl2_q;
	logic [15:0] ctrl3_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic touch_meta_q;
	logic touch_q;
	seq_state_e state_q;
	logic [7:0] pend_q;
	logic [2:0] chan_q;
	logic conv_start_q;
	logic acquire_q;
	logic busy_q;
	logic tmr_start_q;
	logic tmr_halt_q;
	logic [touch_adc_pkg::TICK_W-1:0] tmr_ticks_q;

	logic [5:0] idx;
	logic addr_ok;
	logic access;
	logic wr_ctrl1;
	logic [1:0] mode;
	logic [1:0] wr_mode;
	logic [7:0] tmr_set;
	logic gpio_en;
	logic seq_end;
	logic clr_mode;

	if (INTERVAL_BASE_TICKS + 254 * INTERVAL_STEP_TICKS >= (1 << touch_adc_pkg::TICK_W))
	begin : g_bad_interval
		$error("Interval ticks do not fit the timer counter.");
	end

	conv_timer #(
		.CONV_CLK_CYCLES(CONV_CLK_CYCLES)
	) u_timer (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.tif(tif.timer)
	);

	assign tif.start = tmr_start_q;
	assign tif.halt = tmr_halt_q;
	assign tif.ticks = tmr_ticks_q;

	// Acquisition length in conversion clock ticks for one channel.
	function automatic logic [touch_adc_pkg::TICK_W-1:0] settle_ticks(
		input logic [2:0] chan, input logic [1:0] acq);
		if (chan == touch_adc_pkg::CH_TEMP)
			settle_ticks = touch_adc_pkg::TICK_W'(touch_adc_pkg::TEMP_SETTLE_TICKS);
		else
			settle_ticks = touch_adc_pkg::TICK_W'(touch_adc_pkg::ACQ_BASE_TICKS) << acq;
	endfunction : settle_ticks

	// Interval length in ticks; a zero setting runs as the shortest interval.
	function automatic logic [touch_adc_pkg::TICK_W-1:0] interval_ticks(input logic [7:0] tmr);
		logic [7:0] steps;
		steps = (tmr == 8'h00) ? 8'h00 : tmr - 8'h01;
		interval_ticks = touch_adc_pkg::TICK_W'(INTERVAL_BASE_TICKS) +
			touch_adc_pkg::TICK_W'(steps) * touch_adc_pkg::TICK_W'(INTERVAL_STEP_TICKS);
	endfunction : interval_ticks

	// Drop channels that the shared pin cannot serve in its current function.
	function automatic logic [7:0] pin_filter(input logic [7:0] m, input logic gpio);
		logic [7:0] r;
		r = m;
		if (gpio)
		begin
			r[touch_adc_pkg::CH_AUX] = 1'b0;
			r[touch_adc_pkg::CH_VBAT] = 1'b0;
		end
		else if (r[touch_adc_pkg::CH_AUX] && r[touch_adc_pkg::CH_VBAT])
		begin
			r[touch_adc_pkg::CH_AUX] = 1'b0;
		end
		r[touch_adc_pkg::CH_NONE] = 1'b0;
		pin_filter = r;
	endfunction : pin_filter

	// Channel set for a new sequence, from the mode and current register values.
	function automatic logic [7:0] start_mask(input logic [1:0] md, input logic [15:0] c1,
		input logic [15:0] c3, input logic gpio);
		logic [7:0] m;
		m = 8'h00;
		if (md == touch_adc_pkg::MODE_SINGLE)
			m[c1[touch_adc_pkg::CHAN_LSB +: 3]] = 1'b1;
		else
			m = c3[touch_adc_pkg::SEQ_MASK_LSB +: 8];
		start_mask = pin_filter(m, gpio);
	endfunction : start_mask

	// Highest channel code still pending; sequences run from code 7 downward.
	function automatic logic [2:0] first_chan(input logic [7:0] m);
		first_chan = touch_adc_pkg::CH_NONE;
		for (int i = 1; i < 8; i++)
		begin
			if (m[i])
				first_chan = 3'(i);
		end
	endfunction : first_chan

	// Register decode and sequencer decisions shared by several processes.
	assign idx = paddr_i[7:2];
	assign addr_ok = (paddr_i[1:0] == 2'b00) && ((idx == touch_adc_pkg::CTRL1_IDX) ||
		(idx == touch_adc_pkg::CTRL2_IDX) || (idx == touch_adc_pkg::CTRL3_IDX) ||
		(idx == touch_adc_pkg::STATUS_IDX));
	assign access = psel_i && penable_i && pready_q;
	assign wr_ctrl1 = access && pwrite_i && addr_ok && (idx == touch_adc_pkg::CTRL1_IDX);
	assign mode = ctrl1_q[touch_adc_pkg::MODE_LSB +: 2];
	assign wr_mode = pwdata_i[touch_adc_pkg::MODE_LSB +: 2];
	assign tmr_set = ctrl1_q[touch_adc_pkg::TMR_LSB +: 8];
	assign gpio_en = ctrl2_q[touch_adc_pkg::GPIO_EN_BIT];
	assign seq_end = (state_q == ST_NEXT) && (pend_q == 8'h00);
	assign clr_mode = seq_end && tmr_set == 8'h00 &&
		(mode == touch_adc_pkg::MODE_SINGLE || mode == touch_adc_pkg::MODE_SLAVE);

	// The touch pin is asynchronous; only the second stage is used.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			touch_meta_q <= 1'b0;
			touch_q <= 1'b0;
		end
		else
		begin
			touch_meta_q <= touch_i;
			touch_q <= touch_meta_q;
		end
	end

	// APB slave: data is fetched in the setup cycle so every access has no wait state.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (psel_i && !penable_i)
		begin
			pready_q <= 1'b1;
			pslverr_q <= !addr_ok;
			prdata_q <= 32'h0000_0000;
			if (addr_ok && !pwrite_i)
			begin
				unique case (idx)
					touch_adc_pkg::CTRL1_IDX: prdata_q[15:0] <= ctrl1_q;
					touch_adc_pkg::CTRL2_IDX: prdata_q[15:0] <= ctrl2_q;
					touch_adc_pkg::CTRL3_IDX: prdata_q[15:0] <= ctrl3_q;
					default:
					begin
						prdata_q[touch_adc_pkg::ST_BUSY_BIT] <= busy_q;
						prdata_q[touch_adc_pkg::ST_TOUCH_BIT] <= touch_q;
						prdata_q[touch_adc_pkg::ST_WAIT_BIT] <= (state_q == ST_WAIT_TOUCH);
						prdata_q[touch_adc_pkg::ST_CHAN_LSB +: 3] <= chan_q;
					end
				endcase
			end
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Control registers; a software write beats the end-of-sequence mode clear.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl1_q <= touch_adc_pkg::CTRL1_RESET;
			ctrl2_q <= touch_adc_pkg::CTRL2_RESET;
			ctrl3_q <= touch_adc_pkg::CTRL3_RESET;
		end
		else
		begin
			if (wr_ctrl1)
				ctrl1_q <= pwdata_i[15:0];
			else if (clr_mode)
				ctrl1_q[touch_adc_pkg::MODE_LSB +: 2] <= touch_adc_pkg::MODE_NONE;
			if (access && pwrite_i && addr_ok && idx == touch_adc_pkg::CTRL2_IDX)
				ctrl2_q <= pwdata_i[15:0];
			if (access && pwrite_i && addr_ok && idx == touch_adc_pkg::CTRL3_IDX)
				ctrl3_q <= pwdata_i[15:0];
		end
	end

	// Sequencer: walks the channel set, times acquisition and intervals.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= ST_IDLE;
			pend_q <= 8'h00;
			chan_q <= touch_adc_pkg::CH_NONE;
			conv_start_q <= 1'b0;
			acquire_q <= 1'b0;
			busy_q <= 1'b0;
			tmr_start_q <= 1'b0;
			tmr_halt_q <= 1'b0;
			tmr_ticks_q <= '0;
		end
		else
		begin
			conv_start_q <= 1'b0;
			tmr_start_q <= 1'b0;
			tmr_halt_q <= 1'b0;
			if (wr_ctrl1)
			begin
				// A mode write restarts from scratch and stops any running period.
				tmr_halt_q <= 1'b1;
				acquire_q <= 1'b0;
				unique case (wr_mode)
					touch_adc_pkg::MODE_NONE:
					begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
					end
					touch_adc_pkg::MODE_MASTER:
					begin
						state_q <= touch_q ? ST_NEXT : ST_WAIT_TOUCH;
						pend_q <= start_mask(wr_mode, pwdata_i[15:0], ctrl3_q, gpio_en);
						busy_q <= touch_q;
					end
					default:
					begin
						state_q <= ST_NEXT;
						pend_q <= start_mask(wr_mode, pwdata_i[15:0], ctrl3_q, gpio_en);
						busy_q <= 1'b1;
					end
				endcase
			end
			else
			begin
				unique case (state_q)
					ST_IDLE:
					begin
						busy_q <= 1'b0;
					end
					ST_WAIT_TOUCH:
					begin
						if (touch_q)
						begin
							state_q <= ST_NEXT;
							pend_q <= start_mask(mode, ctrl1_q, ctrl3_q, gpio_en);
							busy_q <= 1'b1;
						end
					end
					ST_NEXT:
					begin
						if (pend_q != 8'h00)
						begin
							chan_q <= first_chan(pend_q);
							pend_q[first_chan(pend_q)] <= 1'b0;
							tmr_ticks_q <= settle_ticks(first_chan(pend_q),
								ctrl1_q[touch_adc_pkg::ACQ_LSB +: 2]);
							tmr_start_q <= 1'b1;
							acquire_q <= 1'b1;
							state_q <= ST_SETTLE;
						end
						else if (mode == touch_adc_pkg::MODE_NONE || clr_mode)
						begin
							state_q <= ST_IDLE;
							busy_q <= 1'b0;
						end
						else if (mode == touch_adc_pkg::MODE_MASTER && !touch_q)
						begin
							state_q <= ST_WAIT_TOUCH;
							busy_q <= 1'b0;
						end
						else
						begin
							// Slave and single count at once; master reaches here only touched.
							tmr_ticks_q <= interval_ticks(tmr_set);
							tmr_start_q <= 1'b1;
							state_q <= ST_INTERVAL;
							busy_q <= 1'b0;
						end
					end
					ST_SETTLE:
					begin
						if (tif.expired)
						begin
							acquire_q <= 1'b0;
							conv_start_q <= 1'b1;
							state_q <= ST_CONVERT;
						end
					end
					ST_CONVERT:
					begin
						if (conv_done_i)
							state_q <= ST_NEXT;
					end
					ST_INTERVAL:
					begin
						if (mode == touch_adc_pkg::MODE_MASTER && !touch_q)
						begin
							tmr_halt_q <= 1'b1;
							state_q <= ST_WAIT_TOUCH;
						end
						else if (tif.expired)
						begin
							state_q <= ST_NEXT;
							pend_q <= start_mask(mode, ctrl1_q, ctrl3_q, gpio_en);
							busy_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Every output comes straight from a flip-flop.
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign conv_start_o = conv_start_q;
	assign conv_channel_o = chan_q;
	assign acquire_o = acquire_q;
	assign busy_o = busy_q;
endmodule : touch_adc_conversion_control

// ### touch_adc_assertions.sv
// Port-level checks of the conversion-control block.
`timescale 1ns/1ns
module touch_adc_assertions #(
	parameter int unsigned CONV_CLK_CYCLES = touch_adc_pkg::CONV_CLK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic conv_start_o,
	input wire logic [2:0] conv_channel_o,
	input wire logic acquire_o,
	input wire logic busy_o
);
	logic [15:0] acq_cnt_q;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	// Length of the last acquisition, kept through the start pulse that ends it.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			acq_cnt_q <= 16'h0000;
		else if (acquire_o)
			acq_cnt_q <= acq_cnt_q + 16'h0001;
		else if (!conv_start_o)
			acq_cnt_q <= 16'h0000;
	end

	property p_ready_after_setup;
		psel_i && !penable_i |=> pready_o ##1 !pready_o;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("pready not a single cycle after setup");
	property p_err_misalign;
		psel_i && !penable_i && paddr_i[1:0] != 2'b00 |=> pslverr_o && prdata_o == 32'h0000_0000;
	endproperty
	a_err_misalign: assert property (p_err_misalign)
		else $error("misaligned access not refused");
	property p_start_pulse;
		conv_start_o |=> !conv_start_o;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("conversion start longer than one cycle");
	property p_start_after_acq;
		conv_start_o |-> $past(acquire_o) && !acquire_o && busy_o;
	endproperty
	a_start_after_acq: assert property (p_start_after_acq)
		else $error("start without preceding acquisition");
	property p_start_chan;
		conv_start_o |-> conv_channel_o != touch_adc_pkg::CH_NONE;
	endproperty
	a_start_chan: assert property (p_start_chan)
		else $error("conversion started on empty channel code");
	property p_temp_settle;
		conv_start_o && conv_channel_o == touch_adc_pkg::CH_TEMP
			|-> acq_cnt_q >= 32 * CONV_CLK_CYCLES && acq_cnt_q <= 33 * CONV_CLK_CYCLES + 2;
	endproperty
	a_temp_settle: assert property (p_temp_settle)
		else $error("temperature settle length wrong");
	property p_acq_min;
		conv_start_o |-> acq_cnt_q >= 4 * CONV_CLK_CYCLES;
	endproperty
	a_acq_min: assert property (p_acq_min)
		else $error("acquisition shorter than four ticks");
	property p_chan_stable;
		acquire_o && $past(acquire_o) |-> $stable(conv_channel_o);
	endproperty
	a_chan_stable: assert property (p_chan_stable)
		else $error("channel changed during acquisition");

	c_temp: cover property (conv_start_o && conv_channel_o == touch_adc_pkg::CH_TEMP);
	c_err: cover property (pslverr_o);
	c_seq_end: cover property ($fell(busy_o));
endmodule : touch_adc_assertions

// ### conv_model.sv
// Behavioural converter that answers each start with a done pulse after a set delay.
`timescale 1ns/1ns
module conv_model (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic conv_start_i,
	input wire logic [7:0] delay_i,
	output logic conv_done_o
);
	logic [7:0] cnt_q;
	logic run_q;

	// One conversion at a time; a long delay mimics a slow converter.
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
			conv_done_o <= 1'b0;
		end
		else
		begin
			conv_done_o <= run_q && cnt_q == 8'h00;
			if (conv_start_i)
				run_q <= 1'b1;
			else if (run_q && cnt_q == 8'h00)
				run_q <= 1'b0;
			cnt_q <= conv_start_i ? delay_i : (cnt_q != 8'h00 ? cnt_q - 8'h01 : cnt_q);
		end
	end
endmodule : conv_model

// ### tb.sv
// Self-checking bench for the conversion-control block.
`timescale 1ns/1ns
module tb;
	localparam int CC = 2;
	localparam int IB = 10;
	localparam int IS = 2;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic touch_i = 1'b0;
	logic [7:0] dly = 8'h01;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, conv_done_i, conv_start_o, acquire_o, busy_o, err;
	logic [2:0] conv_channel_o, ch;
	int mismatches = 0;
	int num_checks = 0;
	int nstart = 0;
	int cyc, na, s;
	logic [7:0] row_a [6] = '{8'h0C, 8'h08, 8'h08, 8'h10, 8'h05, 8'h3C};
	logic [15:0] row_d [6] = '{16'h00A5, 16'h2000, 16'h4040, 16'h1234, 16'h1400, 16'h00FF};
	logic [15:0] row_r [6] = '{16'h00A5, 16'h2000, 16'h4040, 16'h0000, 16'h0000, 16'h0000};
	logic row_e [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

	touch_adc_conversion_control #(.CONV_CLK_CYCLES(CC), .INTERVAL_BASE_TICKS(IB),
		.INTERVAL_STEP_TICKS(IS)) dut_u (.mclk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .touch_i, .conv_done_i,
		.conv_start_o, .conv_channel_o, .acquire_o, .busy_o);
	conv_model model_u (.mclk_i, .rstn_i, .conv_start_i(conv_start_o), .delay_i(dly),
		.conv_done_o(conv_done_i));

	// Free-running clock and a tally of start pulses.
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (conv_start_o === 1'b1) nstart++;

	task test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task rng(input int v, input int lo, input int hi);
		num_checks++;
		if (v < lo || v > hi)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
		end
	endtask : rng

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Setup then access, held until pready is sampled high at a rising edge.
	// The leading edge keeps a release and the next setup out of one time step.
	task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {16'h0000, d};
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1 && ++n < 20);
		if (n >= 20)
		begin
			mismatches++;
			test_done();
		end
		err = pslverr_o;
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	// Counts cycles to the next start, and acquisition cycles on the way.
	task wait_start;
		cyc = 0;
		na = 0;
		do
		begin
			@(negedge mclk_i);
			cyc++;
			if (acquire_o === 1'b1) na++;
		end
		while (conv_start_o !== 1'b1 && cyc < 3000);
		if (cyc >= 3000) begin mismatches++; test_done(); end
		ch = conv_channel_o;
		@(posedge mclk_i);
	endtask : wait_start

	task wait_busy(input logic v);
		cyc = 0;
		do @(negedge mclk_i); while (busy_o !== v && ++cyc < 3000);
		if (cyc >= 3000) begin mismatches++; test_done(); end
		@(posedge mclk_i);
	endtask : wait_busy

	initial
	begin
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		apb(1'b0, 8'h04, 16'h0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h08, 16'h0000);
		chk(rd, 32'h0000_4040);
		// Register rows: write, then read back with the expected response.
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, row_a[i], row_d[i]);
			chk(err, row_e[i]);
			apb(1'b0, row_a[i], 16'h0000);
			chk(err, row_e[i]);
			chk(rd, {16'h0000, row_r[i]});
		end
		// Single conversions on channel 7 over every acquisition code.
		for (int q = 0; q < 4; q++)
		begin
			apb(1'b1, 8'h04, {4'h7, 2'b01, 2'(q), 8'h00});
			wait_start();
			chk(ch, 3'h7);
			rng(na, (4 << q) * CC, (4 << q) * CC + 4);
			wait_busy(1'b0);
			apb(1'b0, 8'h04, 16'h0000);
			chk(rd, {20'h0_0007, 2'b00, 2'(q), 8'h00});
		end
		apb(1'b1, 8'h04, 16'h1400);
		wait_start();
		chk(ch, 3'h1);
		rng(na, 32 * CC, 33 * CC + 4);
		wait_busy(1'b0);
		// Slave sequence with both shared-pin channels selected, slow converter.
		dly <= 8'h14;
		apb(1'b1, 8'h0C, 16'h008C);
		apb(1'b1, 8'h04, 16'h0800);
		wait_start();
		chk(ch, 3'h7);
		wait_start();
		chk(ch, 3'h2);
		wait_busy(1'b0);
		apb(1'b0, 8'h04, 16'h0000);
		chk(rd, 32'h0000_0000);
		// Pin in general-purpose function: only channel 7 converts.
		apb(1'b1, 8'h08, 16'h6040);
		s = nstart;
		apb(1'b1, 8'h04, 16'h0800);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk(nstart - s, 1);
		apb(1'b1, 8'h08, 16'h4040);
		apb(1'b1, 8'h0C, 16'h0080);
		dly <= 8'h01;
		// Slave interval from sequence end to next sequence.
		for (int t = 1; t < 4; t += 2)
		begin
			apb(1'b1, 8'h04, {8'h08, 8'(t)});
			wait_busy(1'b1);
			wait_busy(1'b0);
			wait_busy(1'b1);
			rng(cyc, (IB + (t - 1) * IS) * CC, (IB + (t - 1) * IS) * CC + 6);
			apb(1'b1, 8'h04, 16'h0000);
		end
		// Master mode: repeats while touched, halts on release, restarts on touch.
		touch_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		apb(1'b1, 8'h04, 16'h0C01);
		wait_start();
		wait_start();
		rng(cyc, IB * CC, (IB + 4) * CC + 12);
		touch_i <= 1'b0;
		wait_busy(1'b0);
		s = nstart;
		repeat (100) @(posedge mclk_i);
		chk(nstart - s, 0);
		apb(1'b0, 8'h3C, 16'h0000);
		chk(rd, 32'h0000_0074);
		touch_i <= 1'b1;
		wait_start();
		rng(cyc, 4 * CC, 24);
		apb(1'b1, 8'h04, 16'h0000);
		// Reset in mid-run: a running master sequence and a written pin bit must clear.
		apb(1'b1, 8'h08, 16'h6040);
		apb(1'b1, 8'h04, 16'h0C01);
		wait_start();
		rstn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk({busy_o, acquire_o, conv_channel_o}, 32'h0000_0000);
		rstn_i <= 1'b1;
		touch_i <= 1'b0;
		@(posedge mclk_i);
		apb(1'b0, 8'h04, 16'h0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h08, 16'h0000);
		chk(rd, 32'h0000_4040);
		test_done();
	end
endmodule : tb

bind touch_adc_conversion_control touch_adc_assertions #(.CONV_CLK_CYCLES(CONV_CLK_CYCLES)) chk_u (
	.mclk_i, .rstn_i, .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
	.conv_start_o, .conv_channel_o, .acquire_o, .busy_o);
